/* File: bench/cls_decode_bench.sv */
// self-checking bench for the compact load/store decoder
`timescale 1ns/1ps
`define CHK(a, b) \
   begin \
      samples_checked++; \
      if ((a) !== (b)) begin \
         num_errors++; \
         $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); \
      end \
   end
module cls_decode_bench;
   logic clk, srst, instr_valid, mem_ack, ready, done, undecoded;
   logic [15:0] instr;
   logic [31:0] instr_addr, base_data, index_data, src_data, mem_rdata;
   logic [31:0] load_data;
   logic [3:0] delay;
   logic [2:0] base_idx, index_idx, src_idx;
   cls_pkg::cls_mem_type mem_bus;
   cls_pkg::cls_wb_type wb;
   int num_errors = 0;
   int samples_checked = 0;

   cls_decode i_cls_decode (.i_clk(clk), .i_srst(srst),
      .i_instr_valid(instr_valid), .i_instr(instr),
      .i_instr_addr(instr_addr), .i_rf_base_data(base_data),
      .i_rf_index_data(index_data), .i_rf_src_data(src_data),
      .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata), .o_ready(ready),
      .o_rf_base_idx(base_idx), .o_rf_index_idx(index_idx),
      .o_rf_src_idx(src_idx), .o_mem(mem_bus), .o_wb(wb), .o_done(done),
      .o_undecoded(undecoded));

   cls_mem_model i_cls_mem_model (.i_clk(clk), .i_srst(srst),
      .i_mem(mem_bus), .i_delay(delay), .i_load_data(load_data),
      .i_base_idx(base_idx), .i_index_idx(index_idx), .i_src_idx(src_idx),
      .o_ack(mem_ack), .o_rdata(mem_rdata), .o_base_data(base_data),
      .o_index_data(index_data), .o_src_data(src_data));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   function automatic logic [31:0] rv(input int k);
      return 32'h8000_0000 + 32'h0102_0305 * 32'(k);
   endfunction : rv

   task automatic close_out();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : close_out

   // ------------------------------------------------------------
   // one transfer: offer, check request, wait for completion
   // ------------------------------------------------------------
   task automatic do_xfer(input logic [15:0] ins, input logic [31:0] ia,
         input logic [3:0] dly, input logic [31:0] ld, input logic we,
         input logic [1:0] sz, input logic [31:0] ad, input logic [31:0] wd,
         input logic [2:0] wi, input logic [31:0] wbd);
      int n;
      @(negedge clk);
      instr <= ins;
      instr_addr <= ia;
      delay <= dly;
      load_data <= ld;
      instr_valid <= 1'b1;
      @(negedge clk);
      instr_valid <= 1'b0;
      @(negedge clk);
      `CHK(mem_bus.req, 1'b1)
      `CHK(mem_bus.we, we)
      `CHK(mem_bus.size, sz)
      `CHK(mem_bus.addr, ad)
      if (we) `CHK(mem_bus.wdata, wd)
      n = 0;
      while (done !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      // a pulse seen on the last allowed cycle is not a timeout
      if (done !== 1'b1) begin
         num_errors++;
         close_out();
      end
      `CHK(wb.en, !we)
      `CHK(ready, 1'b1)
      `CHK(mem_bus.req, 1'b0)
      if (!we) `CHK(wb.idx, wi)
      if (!we) `CHK(wb.data, wbd)
   endtask : do_xfer

   task automatic reset_case();
      `CHK(ready, 1'b1)
      `CHK(mem_bus.req, 1'b0)
      `CHK(wb.en, 1'b0)
      `CHK(done, 1'b0)
   endtask : reset_case

   // offset 255 from a base with bit 1 set, then 211 words
   task automatic pc_load_case();
      do_xfer(16'h4DFF, 32'h0000_1002, 4'h0, 32'h1357_9BDF, 1'b0,
         cls_pkg::SIZE_WORD, 32'h0000_1400, 32'h0, 3'h5, 32'h1357_9BDF);
      do_xfer(16'h4BD3, 32'h0000_2000, 4'h5, 32'h2468_ACE0, 1'b0,
         cls_pkg::SIZE_WORD, 32'h0000_2350, 32'h0, 3'h3, 32'h2468_ACE0);
   endtask : pc_load_case

   // all four load/store and byte/word combinations, slow and fast memory
   task automatic reg_off_case();
      logic [31:0] wd, wbd;
      logic [15:0] ins;
      for (int lb = 0; lb < 4; lb++) begin
         ins = 16'h51AA | (16'(lb) << 10);
         wd = rv(2);
         wbd = 32'hC3D2_E1F0;
         if (lb[0]) begin
            wd = {24'h0, wd[7:0]};
            wbd = 32'h0000_00F0;
         end
         do_xfer(ins, 32'h0, 4'(lb * 2), 32'hC3D2_E1F0, !lb[1],
            lb[0] ? cls_pkg::SIZE_BYTE : cls_pkg::SIZE_WORD,
            rv(5) + rv(6), wd, 3'h2, wbd);
      end
   endtask : reg_off_case

   // halfword store and the three extending loads
   task automatic sign_case();
      logic [31:0] wd, wbd;
      logic [15:0] ins;
      for (int hs = 0; hs < 4; hs++) begin
         ins = 16'h527C | (16'(hs) << 10);
         wd = rv(4);
         wd = {16'h0, wd[15:0]};
         case (hs)
            1: wbd = 32'h0000_8796;
            2: wbd = 32'hFFFF_FF96;
            default: wbd = 32'hFFFF_8796;
         endcase
         do_xfer(ins, 32'h0, 4'(hs), 32'h3C5A_8796, hs == 0,
            hs == 2 ? cls_pkg::SIZE_BYTE : cls_pkg::SIZE_HALF,
            rv(7) + rv(1), wd, 3'h4, wbd);
      end
   endtask : sign_case

   // neighbours of the decoded groups must be ignored
   task automatic undecoded_case();
      logic [15:0] bad [3];
      bad = '{16'h6000, 16'h4000, 16'hB800};
      for (int k = 0; k < 3; k++) begin
         @(negedge clk);
         instr <= bad[k];
         instr_valid <= 1'b1;
         @(negedge clk);
         instr_valid <= 1'b0;
         `CHK(undecoded, 1'b1)
         `CHK(mem_bus.req, 1'b0)
         @(negedge clk);
         `CHK(undecoded, 1'b0)
         `CHK(ready, 1'b1)
      end
   endtask : undecoded_case

   initial begin
      srst = 1'b1;
      instr_valid = 1'b0;
      instr = 16'h0;
      instr_addr = 32'h0;
      delay = 4'h0;
      load_data = 32'h0;
      for (int k = 0; k < 8; k++) begin
         i_cls_mem_model.regs[k] = rv(k);
      end
      repeat (8) @(negedge clk);
      reset_case();
      srst = 1'b0;
      pc_load_case();
      reg_off_case();
      sign_case();
      undecoded_case();
      repeat (4) @(negedge clk);
      close_out();
   end
endmodule : cls_decode_bench

/* File: bench/cls_mem_model.sv */
// partner model: register file read ports and data memory with ack delay
`timescale 1ns/1ps
module cls_mem_model (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire cls_pkg::cls_mem_type i_mem,
   input wire logic [3:0] i_delay,
   input wire logic [31:0] i_load_data,
   input wire logic [2:0] i_base_idx,
   input wire logic [2:0] i_index_idx,
   input wire logic [2:0] i_src_idx,
   output logic o_ack,
   output logic [31:0] o_rdata,
   output logic [31:0] o_base_data,
   output logic [31:0] o_index_data,
   output logic [31:0] o_src_data
);
   // loaded by the bench before traffic starts
   logic [31:0] regs [8];
   logic [3:0] wait_r;

   assign o_base_data = regs[i_base_idx];
   assign o_index_data = regs[i_index_idx];
   assign o_src_data = regs[i_src_idx];

   // ------------------------------------------------------------
   // memory answer
   // ------------------------------------------------------------
   // read data scrambles outside the ack cycle, so stale data never
   // passes for a fresh answer
   always_ff @(posedge i_clk) begin
      if (i_srst || !i_mem.req || o_ack) begin
         wait_r <= 4'h0;
         o_ack <= 1'b0;
         o_rdata <= i_srst ? 32'hA5A5_A5A5 : ~o_rdata;
      end else if (wait_r == i_delay) begin
         o_ack <= 1'b1;
         o_rdata <= i_load_data;
      end else begin
         wait_r <= wait_r + 4'h1;
         o_rdata <= ~o_rdata;
      end
   end
endmodule : cls_mem_model

/* File: src/cls_decode.sv */
// decode and execute of compact pc-relative and register-offset transfers
`timescale 1ns/1ps
// Functional notes
// - pc load reads word at pc plus offset
// - offset field counts words, scaled by four
// - pc base is address plus four, bit1 cleared
// - address is base plus low index register
// - word store writes full source register
// - byte store writes one source byte
// - word load writes whole word to destination
// - byte load reads one byte to destination
// - bit9 selects sign group; bit11 selects sign extension in it
// - sign group address is base plus index
// - selectors zero stores low halfword
// - unsigned halfword load clears bits 31:16
// - signed byte load replicates bit 7
// - signed halfword load replicates bit 15
module cls_decode (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_instr_valid,
   input wire logic [15:0] i_instr,
   input wire logic [31:0] i_instr_addr,
   input wire logic [31:0] i_rf_base_data,
   input wire logic [31:0] i_rf_index_data,
   input wire logic [31:0] i_rf_src_data,
   input wire logic i_mem_ack,
   input wire logic [31:0] i_mem_rdata,
   output logic o_ready,
   output logic [2:0] o_rf_base_idx,
   output logic [2:0] o_rf_index_idx,
   output logic [2:0] o_rf_src_idx,
   output cls_pkg::cls_mem_type o_mem,
   output cls_pkg::cls_wb_type o_wb,
   output logic o_done,
   output logic o_undecoded
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_REGRD, ST_MEM} cls_state_type;

   cls_state_type state_r, state_nxt;
   cls_pkg::cls_op_type op_r, op_nxt, op_dec;
   logic [15:0] instr_r, instr_nxt;
   logic [31:0] pc_r, pc_nxt;
   logic [2:0] base_idx_r, base_idx_nxt;
   logic [2:0] index_idx_r, index_idx_nxt;
   logic [2:0] src_idx_r, src_idx_nxt;
   cls_pkg::cls_mem_type mem_r, mem_nxt;
   cls_pkg::cls_wb_type wb_r, wb_nxt;
   logic ready_r, ready_nxt;
   logic done_r, done_nxt;
   logic undec_r, undec_nxt;
   logic is_load;
   logic is_signed;
   logic [1:0] size_sel;
   logic [31:0] pc_base;
   logic [31:0] pc_offs;
   logic [31:0] ext_data;

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   always_comb begin
      op_dec = cls_pkg::OP_NONE;
      if (i_instr[15:11] == cls_pkg::PC_LOAD_TOP) begin
         op_dec = cls_pkg::OP_PC_WORD_LOAD;
      end else if (i_instr[15:12] == cls_pkg::REG_GROUP_TOP) begin
         unique case ({i_instr[cls_pkg::GROUP_BIT],
                       i_instr[cls_pkg::SEL_HI_BIT],
                       i_instr[cls_pkg::SEL_LO_BIT]})
            3'h0: op_dec = cls_pkg::OP_WORD_STORE;
            3'h1: op_dec = cls_pkg::OP_BYTE_STORE;
            3'h2: op_dec = cls_pkg::OP_WORD_LOAD;
            3'h3: op_dec = cls_pkg::OP_BYTE_LOAD_UNSIGNED;
            3'h4: op_dec = cls_pkg::OP_HALFWORD_STORE;
            3'h5: op_dec = cls_pkg::OP_HALFWORD_LOAD_UNSIGNED;
            3'h6: op_dec = cls_pkg::OP_BYTE_LOAD_SIGNED;
            3'h7: op_dec = cls_pkg::OP_HALFWORD_LOAD_SIGNED;
         endcase
      end
   end

   // transfer attributes of the latched operation
   always_comb begin
      is_load = 1'b1;
      is_signed = 1'b0;
      size_sel = cls_pkg::SIZE_WORD;
      unique case (op_r)
         cls_pkg::OP_WORD_STORE: is_load = 1'b0;
         cls_pkg::OP_BYTE_STORE: begin
            is_load = 1'b0;
            size_sel = cls_pkg::SIZE_BYTE;
         end
         cls_pkg::OP_HALFWORD_STORE: begin
            is_load = 1'b0;
            size_sel = cls_pkg::SIZE_HALF;
         end
         cls_pkg::OP_BYTE_LOAD_UNSIGNED: size_sel = cls_pkg::SIZE_BYTE;
         cls_pkg::OP_HALFWORD_LOAD_UNSIGNED: size_sel = cls_pkg::SIZE_HALF;
         cls_pkg::OP_BYTE_LOAD_SIGNED: begin
            is_signed = 1'b1;
            size_sel = cls_pkg::SIZE_BYTE;
         end
         cls_pkg::OP_HALFWORD_LOAD_SIGNED: begin
            is_signed = 1'b1;
            size_sel = cls_pkg::SIZE_HALF;
         end
         default: ;
      endcase
   end

   // ------------------------------------------------------------
   // address and data paths
   // ------------------------------------------------------------
   assign pc_base = (pc_r + cls_pkg::PC_AHEAD) & cls_pkg::PC_ALIGN_MASK;
   assign pc_offs = {22'h0, instr_r[cls_pkg::OFFS_LSB +: cls_pkg::OFFS_W],
                     2'h0};

   cls_load_extend u_ext (
      .i_size(size_sel),
      .i_signed(is_signed),
      .i_data(i_mem_rdata),
      .o_data(ext_data)
   );

   // ------------------------------------------------------------
   // sequencing
   // ------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      op_nxt = op_r;
      instr_nxt = instr_r;
      pc_nxt = pc_r;
      base_idx_nxt = base_idx_r;
      index_idx_nxt = index_idx_r;
      src_idx_nxt = src_idx_r;
      mem_nxt = mem_r;
      wb_nxt = wb_r;
      wb_nxt.en = 1'b0;
      done_nxt = 1'b0;
      undec_nxt = 1'b0;
      ready_nxt = ready_r;
      unique case (state_r)
         ST_IDLE: begin
            if (i_instr_valid) begin
               if (op_dec == cls_pkg::OP_NONE) begin
                  undec_nxt = 1'b1;
               end else begin
                  op_nxt = op_dec;
                  instr_nxt = i_instr;
                  pc_nxt = i_instr_addr;
                  base_idx_nxt = i_instr[cls_pkg::BASE_LSB +: cls_pkg::RIDX_W];
                  index_idx_nxt = i_instr[cls_pkg::INDEX_LSB +: cls_pkg::RIDX_W];
                  src_idx_nxt = (op_dec == cls_pkg::OP_PC_WORD_LOAD) ?
                     i_instr[cls_pkg::PCDEST_LSB +: cls_pkg::RIDX_W] :
                     i_instr[cls_pkg::DEST_LSB +: cls_pkg::RIDX_W];
                  ready_nxt = 1'b0;
                  state_nxt = ST_REGRD;
               end
            end
         end
         ST_REGRD: begin
            mem_nxt.req = 1'b1;
            mem_nxt.we = ~is_load;
            mem_nxt.size = size_sel;
            if (op_r == cls_pkg::OP_PC_WORD_LOAD) begin
               mem_nxt.addr = pc_base + pc_offs;
            end else begin
               mem_nxt.addr = i_rf_base_data + i_rf_index_data;
            end
            // stores send data right aligned; zeros fill the unused upper bits
            unique case (size_sel)
               cls_pkg::SIZE_BYTE:
                  mem_nxt.wdata = {24'h0, i_rf_src_data[7:0]};
               cls_pkg::SIZE_HALF:
                  mem_nxt.wdata = {16'h0, i_rf_src_data[15:0]};
               default: mem_nxt.wdata = i_rf_src_data;
            endcase
            state_nxt = ST_MEM;
         end
         ST_MEM: begin
            if (i_mem_ack) begin
               mem_nxt.req = 1'b0;
               mem_nxt.we = 1'b0;
               wb_nxt.en = is_load;
               wb_nxt.idx = src_idx_r;
               wb_nxt.data = ext_data;
               done_nxt = 1'b1;
               ready_nxt = 1'b1;
               state_nxt = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         state_r <= ST_IDLE;
         op_r <= cls_pkg::OP_NONE;
         instr_r <= 16'h0;
         pc_r <= 32'h0;
         base_idx_r <= 3'h0;
         index_idx_r <= 3'h0;
         src_idx_r <= 3'h0;
         mem_r <= '0;
         wb_r <= '0;
         ready_r <= 1'b1;
         done_r <= 1'b0;
         undec_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         op_r <= op_nxt;
         instr_r <= instr_nxt;
         pc_r <= pc_nxt;
         base_idx_r <= base_idx_nxt;
         index_idx_r <= index_idx_nxt;
         src_idx_r <= src_idx_nxt;
         mem_r <= mem_nxt;
         wb_r <= wb_nxt;
         ready_r <= ready_nxt;
         done_r <= done_nxt;
         undec_r <= undec_nxt;
      end
   end

   assign o_ready = ready_r;
   assign o_rf_base_idx = base_idx_r;
   assign o_rf_index_idx = index_idx_r;
   assign o_rf_src_idx = src_idx_r;
   assign o_mem = mem_r;
   assign o_wb = wb_r;
   assign o_done = done_r;
   assign o_undecoded = undec_r;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);

   pc_load_addr_a: assert property (
      $rose(mem_r.req) && op_r == cls_pkg::OP_PC_WORD_LOAD |->
      mem_r.addr == (((pc_r + 32'h4) & 32'hFFFF_FFFD) +
                     {22'h0, instr_r[7:0], 2'h0}) && !mem_r.we)
      else $error("pc relative load address wrong");
   pc_word_align_a: assert property (
      mem_r.req && op_r == cls_pkg::OP_PC_WORD_LOAD |-> mem_r.addr[1:0] == 2'h0)
      else $error("pc relative load not word aligned");
   reg_index_addr_a: assert property (
      $rose(mem_r.req) && op_r != cls_pkg::OP_PC_WORD_LOAD |->
      mem_r.addr == $past(i_rf_base_data) + $past(i_rf_index_data))
      else $error("register offset address wrong");
   decode_op_a: assert property (
      state_r == ST_IDLE && i_instr_valid && i_instr[15:11] == 5'h09 |=>
      op_r == cls_pkg::OP_PC_WORD_LOAD && src_idx_r == $past(i_instr[10:8]))
      else $error("pc relative load not decoded");
   group_split_a: assert property (
      state_r == ST_IDLE && i_instr_valid && i_instr[15:12] == 4'h5 &&
      i_instr[11:9] == 3'h3 |=> op_r == cls_pkg::OP_HALFWORD_LOAD_UNSIGNED)
      else $error("sign group selector misdecoded");
   word_store_a: assert property (
      $rose(mem_r.req) && op_r == cls_pkg::OP_WORD_STORE |->
      mem_r.we && mem_r.size == 2'h2 && mem_r.wdata == $past(i_rf_src_data))
      else $error("word store data wrong");
   byte_store_a: assert property (
      $rose(mem_r.req) && op_r == cls_pkg::OP_BYTE_STORE |->
      mem_r.we && mem_r.wdata == {24'h0, $past(i_rf_src_data[7:0])})
      else $error("byte store data wrong");
   half_store_a: assert property (
      $rose(mem_r.req) && op_r == cls_pkg::OP_HALFWORD_STORE |->
      mem_r.size == 2'h1 && mem_r.wdata == {16'h0, $past(i_rf_src_data[15:0])})
      else $error("halfword store data wrong");
   word_load_wb_a: assert property (
      state_r == ST_MEM && i_mem_ack && op_r == cls_pkg::OP_WORD_LOAD |=>
      wb_r.en && wb_r.data == $past(i_mem_rdata) ##1 !wb_r.en)
      else $error("word load writeback wrong");
   byte_zero_fill_a: assert property (
      state_r == ST_MEM && i_mem_ack && op_r == cls_pkg::OP_BYTE_LOAD_UNSIGNED
      |=> wb_r.en && wb_r.data == {24'h0, $past(i_mem_rdata[7:0])})
      else $error("byte load not zero filled");
   half_zero_fill_a: assert property (
      wb_r.en && $past(op_r) == cls_pkg::OP_HALFWORD_LOAD_UNSIGNED |->
      wb_r.data[31:16] == 16'h0)
      else $error("halfword load not zero filled");
   byte_sign_a: assert property (
      wb_r.en && $past(op_r) == cls_pkg::OP_BYTE_LOAD_SIGNED |->
      wb_r.data[31:8] == {24{wb_r.data[7]}})
      else $error("signed byte not extended");
   half_sign_a: assert property (
      wb_r.en && $past(op_r) == cls_pkg::OP_HALFWORD_LOAD_SIGNED |->
      wb_r.data[31:16] == {16{wb_r.data[15]}})
      else $error("signed halfword not extended");
endmodule : cls_decode

/* File: src/cls_load_extend.sv */
// load data extension: zero or sign fill by transfer size
`timescale 1ns/1ps
module cls_load_extend (
   input wire logic [1:0] i_size,
   input wire logic i_signed,
   input wire logic [31:0] i_data,
   output logic [31:0] o_data
);
   always_comb begin
      o_data = i_data;
      if (i_size == cls_pkg::SIZE_BYTE) begin
         o_data = {{24{i_signed & i_data[7]}}, i_data[7:0]};
      end else if (i_size == cls_pkg::SIZE_HALF) begin
         o_data = {{16{i_signed & i_data[15]}}, i_data[15:0]};
      end
   end
endmodule : cls_load_extend

/* File: src/cls_pkg.sv */
// shared constants and carrier types for the compact load/store decoder
package cls_pkg;
   // ------------------------------------------------------------
   // instruction field layout
   // ------------------------------------------------------------
   localparam int DEST_LSB = 0;
   localparam int BASE_LSB = 3;
   localparam int INDEX_LSB = 6;
   localparam int PCDEST_LSB = 8;
   localparam int OFFS_LSB = 0;
   localparam int OFFS_W = 8;
   localparam int RIDX_W = 3;
   localparam int SEL_HI_BIT = 11;
   localparam int SEL_LO_BIT = 10;
   localparam int GROUP_BIT = 9;
   localparam logic [4:0] PC_LOAD_TOP = 5'h09;
   localparam logic [3:0] REG_GROUP_TOP = 4'h5;
   // ------------------------------------------------------------
   // address formation
   // ------------------------------------------------------------
   localparam logic [31:0] PC_AHEAD = 32'h0000_0004;
   localparam logic [31:0] PC_ALIGN_MASK = 32'hFFFF_FFFD;
   localparam int WORD_SHIFT = 2;
   // ------------------------------------------------------------
   // transfer sizes
   // ------------------------------------------------------------
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;

   typedef enum logic [3:0] {
      OP_NONE,
      OP_PC_WORD_LOAD,
      OP_WORD_STORE,
      OP_BYTE_STORE,
      OP_WORD_LOAD,
      OP_BYTE_LOAD_UNSIGNED,
      OP_HALFWORD_STORE,
      OP_HALFWORD_LOAD_UNSIGNED,
      OP_BYTE_LOAD_SIGNED,
      OP_HALFWORD_LOAD_SIGNED
   } cls_op_type;

   typedef struct packed {
      logic req;
      logic we;
      logic [1:0] size;
      logic [31:0] addr;
      logic [31:0] wdata;
   } cls_mem_type;

   typedef struct packed {
      logic en;
      logic [2:0] idx;
      logic [31:0] data;
   } cls_wb_type;
endpackage : cls_pkg
